// file: logic/ptr_pkg.sv
// types of the protection and loop tuning register bank
package ptr_pkg;
  typedef enum logic [1:0] {PTR_FULL, PTR_REDUCED, PTR_DIODE} ptr_pstate_t;
  typedef enum logic [1:0] {PTR_DK_HALF, PTR_DK_NORMAL, PTR_DK_QUARTER} ptr_decay_t;
  typedef struct packed {
    logic [8:0]  prot_dis;
    logic [6:0]  uv_cfg;
    logic [11:0] pscomp;
    logic [13:0] modtune;
  } ptr_bank_t;
  typedef struct packed {
    logic       dead_band_reduced;
    ptr_decay_t decay;
    logic [2:0] peak_cap_pf;
    logic [2:0] hpass_cap_pf;
    logic       gain_double;
  } ptr_tune_t;
endpackage

// file: logic/ptr_regs.svh
// register offsets, field positions, reset values and timing of the tuning register bank
`ifndef PTR_REGS_SVH
`define PTR_REGS_SVH
`define PTR_OFS_PROT_DIS   8'hdf
`define PTR_OFS_UV_CFG     8'he1
`define PTR_OFS_PSCOMP     8'he2
`define PTR_OFS_MODTUNE    8'he3
`define PTR_RST_PROT_DIS   9'h000
`define PTR_RST_UV_CFG     7'h00
`define PTR_RST_PSCOMP     12'h000
`define PTR_RST_MODTUNE    14'h0000
`define PTR_RST_CLAMP      7'h14
`define PTR_PD_OV_TRIP     0
`define PTR_PD_IIN_OC      1
`define PTR_PD_I_OC        2
`define PTR_PD_V_OC        3
`define PTR_PD_IPH_LIM     4
`define PTR_PD_UV_TRIP     5
`define PTR_PD_OT          6
`define PTR_PD_HIGH_WARN   7
`define PTR_PD_LOW_WARN    8
`define PTR_UV_LVL_LSB     0
`define PTR_UV_DLY_LSB     4
`define PTR_UV_ACT_BIT     6
`define PTR_PS_CLAMP_LSB   3
`define PTR_PS_ENTDE_LSB   6
`define PTR_PS_R2F_LSB     9
`define PTR_MT_DB1_BIT     0
`define PTR_MT_DK1_LSB     1
`define PTR_MT_DB2_BIT     3
`define PTR_MT_DK2_LSB     4
`define PTR_MT_DB3_BIT     6
`define PTR_MT_DK3_LSB     7
`define PTR_MT_PKC_LSB     9
`define PTR_MT_HPC_LSB     11
`define PTR_MT_GAIN_BIT    13
`define PTR_UV_HYST_MV     19
`define PTR_UVW_ABOVE_MV   66
`define PTR_UVW_HYST_MV    17
`define PTR_STEP_MV        20
`define PTR_CLK_MHZ        200
`define PTR_DLY0_US        10
`define PTR_DLY1_US        20
`define PTR_DLY2_US        40
`define PTR_DLY3_US        120
`endif

// file: logic/ptr_top.sv
// register bank for protection disables, undervoltage handling and transient tuning
// Functional notes
// - nine disable bits, msb first: low_voltage_warning_disable, high_voltage_warning_disable, ot, uv trip, iph, ocv, oci, iin, ov
// - trip margin below dac: 105,141,178,214,252,291,328,402 mV, 19 mV hysteresis
// - warning sits 66 mV above trip threshold, 17 mV hysteresis
// - disable bits suppress undervoltage trip and warning
// - trip must persist 10, 20, 40 or 120 us before acting
// - action bit: zero reports only, one requests hiccup restart
// - compensation bottom clamp 20, 40, 60 or 80 mV
// - offset 0..140 mV in 20 mV steps entering diode emulation only
// - offset 0..60 mV only on reduced to full transition
// - bit 5 and bits 2:0 of compensation register stored, no effect
// - one phase: bit 0 dead band, bits 2:1 decay half/normal/quarter/half
// - two phase: bit 3 dead band, bits 5:4 decay, same coding
// - three or more phases: bit 6 dead band, bits 8:7 decay
// - per-phase tuning applies only when speed-up mode is zero
// - peak and high-pass capacitors 1 to 4 pF
// - bit 13 doubles balance gain
// - reduced state runs one or two phases per count; full runs more
// - selected bank of eight supplies register defaults
`timescale 1ns/10ps
`include "ptr_regs.svh"
module ptr_top #(
  parameter int MAX_PHASES = 6,
  parameter int DLY0_CYC   = `PTR_DLY0_US * `PTR_CLK_MHZ,
  parameter int DLY1_CYC   = `PTR_DLY1_US * `PTR_CLK_MHZ,
  parameter int DLY2_CYC   = `PTR_DLY2_US * `PTR_CLK_MHZ,
  parameter int DLY3_CYC   = `PTR_DLY3_US * `PTR_CLK_MHZ
) (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic [7:0]           cmd_code,
  input  wire logic                 cmd_wr,
  input  wire logic [15:0]          cmd_wdata,
  input  wire logic                 cmd_rd,
  output logic [15:0]               cmd_rdata_r,
  output logic                      cmd_rvalid_r,
  output logic                      cmd_unmapped_r,
  input  wire logic [2:0]           nonvolatile_bank_select,
  input  wire logic                 bank_load,
  input  wire ptr_pkg::ptr_bank_t   bank_data,
  output logic [2:0]                bank_addr_r,
  input  wire logic [11:0]          vout_mv,
  input  wire logic [11:0]          dac_mv,
  output logic                      low_voltage_trip_r,
  output logic                      low_voltage_warn_r,
  output logic                      hiccup_req_r,
  output logic [8:0]                prot_disable_r,
  input  wire ptr_pkg::ptr_pstate_t pstate,
  input  wire logic [1:0]           reduced_phase_count,
  input  wire logic [2:0]           speedup_mode,
  output logic [2:0]                phases_run_r,
  output logic [7:0]                comp_offset_mv_r,
  output logic [6:0]                clamp_mv_r,
  output logic                      tune_active_r,
  output ptr_pkg::ptr_tune_t        tune_r
);
  import ptr_pkg::*;

  // the persistence counter is 16 bits wide, so longer delays cannot be served
  if (MAX_PHASES < 3 || MAX_PHASES > 7 || DLY0_CYC < 1 || DLY1_CYC < 1 ||
      DLY2_CYC < 1 || DLY3_CYC < 1 || DLY0_CYC > 65535 || DLY1_CYC > 65535 ||
      DLY2_CYC > 65535 || DLY3_CYC > 65535) begin : g_param_check
    $error("ptr_top: unsupported parameter values");
  end

  function automatic logic [8:0] uv_level_mv(input logic [3:0] code);
    logic [8:0] v;
    v = 9'h000;
    unique case (code[2:0])
      3'h0: v = 9'h069;
      3'h1: v = 9'h08d;
      3'h2: v = 9'h0b2;
      3'h3: v = 9'h0d6;
      3'h4: v = 9'h0fc;
      3'h5: v = 9'h123;
      3'h6: v = 9'h148;
      3'h7: v = 9'h192;
    endcase
    // codes above 7h are undefined; held at the widest margin
    if (code[3]) begin
      v = 9'h192;
    end
    return v;
  endfunction

  function automatic ptr_decay_t decay_dec(input logic [1:0] code);
    ptr_decay_t d;
    d = PTR_DK_HALF;
    unique case (code)
      2'h1: d = PTR_DK_NORMAL;
      2'h2: d = PTR_DK_QUARTER;
      default: d = PTR_DK_HALF;
    endcase
    return d;
  endfunction

  function automatic logic [7:0] step_mv(input logic [2:0] code);
    return 8'(code * `PTR_STEP_MV);
  endfunction

  function automatic logic [2:0] cap_pf(input logic [1:0] code);
    return 3'(code) + 3'h1;
  endfunction

  // ---------------- register file ----------------
  logic [8:0]  prot_dis_r, prot_dis_nxt;
  logic [6:0]  uv_cfg_r, uv_cfg_nxt;
  logic [11:0] pscomp_r, pscomp_nxt;
  logic [13:0] modtune_r, modtune_nxt;
  logic [15:0] rdata_nxt;
  logic        rvalid_nxt, unmapped_nxt;
  logic [2:0]  bank_addr_nxt;

  always_comb begin
    prot_dis_nxt  = prot_dis_r;
    uv_cfg_nxt    = uv_cfg_r;
    pscomp_nxt    = pscomp_r;
    modtune_nxt   = modtune_r;
    bank_addr_nxt = nonvolatile_bank_select;
    if (bank_load) begin
      prot_dis_nxt = bank_data.prot_dis;
      uv_cfg_nxt   = bank_data.uv_cfg;
      pscomp_nxt   = bank_data.pscomp;
      modtune_nxt  = bank_data.modtune;
    end
    // a host write in the load cycle lands last, so the host value survives
    if (cmd_wr) begin
      unique case (cmd_code)
        `PTR_OFS_PROT_DIS: prot_dis_nxt = cmd_wdata[8:0];
        `PTR_OFS_UV_CFG:   uv_cfg_nxt   = cmd_wdata[6:0];
        `PTR_OFS_PSCOMP:   pscomp_nxt   = cmd_wdata[11:0];
        `PTR_OFS_MODTUNE:  modtune_nxt  = cmd_wdata[13:0];
        default: ;
      endcase
    end
    rvalid_nxt   = cmd_rd;
    unmapped_nxt = 1'b0;
    rdata_nxt    = 16'h0000;
    if (cmd_rd) begin
      unique case (cmd_code)
        `PTR_OFS_PROT_DIS: rdata_nxt = {7'h00, prot_dis_r};
        `PTR_OFS_UV_CFG:   rdata_nxt = {9'h000, uv_cfg_r};
        `PTR_OFS_PSCOMP:   rdata_nxt = {4'h0, pscomp_r};
        `PTR_OFS_MODTUNE:  rdata_nxt = {2'h0, modtune_r};
        default:           unmapped_nxt = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prot_dis_r     <= `PTR_RST_PROT_DIS;
      uv_cfg_r       <= `PTR_RST_UV_CFG;
      pscomp_r       <= `PTR_RST_PSCOMP;
      modtune_r      <= `PTR_RST_MODTUNE;
      cmd_rdata_r    <= 16'h0000;
      cmd_rvalid_r   <= 1'b0;
      cmd_unmapped_r <= 1'b0;
      bank_addr_r    <= 3'h0;
    end else begin
      prot_dis_r     <= prot_dis_nxt;
      uv_cfg_r       <= uv_cfg_nxt;
      pscomp_r       <= pscomp_nxt;
      modtune_r      <= modtune_nxt;
      cmd_rdata_r    <= rdata_nxt;
      cmd_rvalid_r   <= rvalid_nxt;
      cmd_unmapped_r <= unmapped_nxt;
      bank_addr_r    <= bank_addr_nxt;
    end
  end

  // ---------------- undervoltage ----------------
  // signed 14-bit so a large margin under a low dac cannot wrap
  logic signed [13:0] trip_thr, warn_thr, vout_s;
  logic               trip_raw_nxt, trip_raw_r;
  logic               warn_nxt, trip_nxt, hiccup_nxt;
  logic [15:0]        dly_cnt_r, dly_cnt_nxt, dly_lim;
  logic               trip_dis, warn_dis;

  always_comb begin
    trip_dis = prot_dis_r[`PTR_PD_UV_TRIP];
    warn_dis = prot_dis_r[`PTR_PD_LOW_WARN];
    vout_s   = 14'(vout_mv);
    trip_thr = 14'(dac_mv) - 14'(uv_level_mv(uv_cfg_r[`PTR_UV_LVL_LSB +: 4]));
    warn_thr = trip_thr + 14'(`PTR_UVW_ABOVE_MV);
    unique case (uv_cfg_r[`PTR_UV_DLY_LSB +: 2])
      2'h0: dly_lim = 16'(DLY0_CYC);
      2'h1: dly_lim = 16'(DLY1_CYC);
      2'h2: dly_lim = 16'(DLY2_CYC);
      2'h3: dly_lim = 16'(DLY3_CYC);
    endcase
    trip_raw_nxt = trip_raw_r;
    if (vout_s < trip_thr) begin
      trip_raw_nxt = 1'b1;
    end else if (vout_s >= trip_thr + 14'(`PTR_UV_HYST_MV)) begin
      trip_raw_nxt = 1'b0;
    end
    warn_nxt = low_voltage_warn_r;
    if (vout_s < warn_thr) begin
      warn_nxt = 1'b1;
    end else if (vout_s >= warn_thr + 14'(`PTR_UVW_HYST_MV)) begin
      warn_nxt = 1'b0;
    end
    if (warn_dis) begin
      warn_nxt = 1'b0;
    end
    if (trip_dis) begin
      trip_raw_nxt = 1'b0;
    end
    dly_cnt_nxt = 16'h0000;
    trip_nxt    = 1'b0;
    if (trip_raw_r) begin
      if (dly_cnt_r >= dly_lim) begin
        dly_cnt_nxt = dly_cnt_r;
        trip_nxt    = 1'b1;
      end else begin
        dly_cnt_nxt = dly_cnt_r + 16'h0001;
      end
    end
    if (trip_dis) begin
      trip_nxt = 1'b0;
    end
    hiccup_nxt = trip_nxt & uv_cfg_r[`PTR_UV_ACT_BIT];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trip_raw_r         <= 1'b0;
      dly_cnt_r          <= 16'h0000;
      low_voltage_trip_r <= 1'b0;
      low_voltage_warn_r <= 1'b0;
      hiccup_req_r       <= 1'b0;
      prot_disable_r     <= `PTR_RST_PROT_DIS;
    end else begin
      trip_raw_r         <= trip_raw_nxt;
      dly_cnt_r          <= dly_cnt_nxt;
      low_voltage_trip_r <= trip_nxt;
      low_voltage_warn_r <= warn_nxt;
      hiccup_req_r       <= hiccup_nxt;
      prot_disable_r     <= prot_dis_nxt;
    end
  end

  // ---------------- power state and tuning ----------------
  ptr_pstate_t pstate_r;
  logic [7:0]  offset_nxt;
  logic [6:0]  clamp_nxt;
  logic [2:0]  phases_nxt;
  logic        tune_act_nxt;
  ptr_tune_t   tune_nxt;

  always_comb begin
    offset_nxt = comp_offset_mv_r;
    // offset holds until the next state change; no offset on other transitions
    if (pstate != pstate_r) begin
      offset_nxt = 8'h00;
      if (pstate == PTR_DIODE) begin
        offset_nxt = step_mv(pscomp_r[`PTR_PS_ENTDE_LSB +: 3]);
      end else if (pstate == PTR_FULL && pstate_r == PTR_REDUCED) begin
        offset_nxt = step_mv({1'b0, pscomp_r[`PTR_PS_R2F_LSB +: 2]});
      end
    end
    clamp_nxt = 7'(step_mv({1'b0, pscomp_r[`PTR_PS_CLAMP_LSB +: 2]})
                   + 8'(`PTR_STEP_MV));
    unique case (pstate)
      PTR_REDUCED: phases_nxt = (reduced_phase_count == 2'h2) ? 3'h2 : 3'h1;
      default:     phases_nxt = 3'(MAX_PHASES);
    endcase
    tune_act_nxt = (speedup_mode == 3'h0);
    tune_nxt.dead_band_reduced = 1'b0;
    tune_nxt.decay             = PTR_DK_NORMAL;
    if (tune_act_nxt) begin
      if (phases_nxt == 3'h1) begin
        tune_nxt.dead_band_reduced = modtune_r[`PTR_MT_DB1_BIT];
        tune_nxt.decay             = decay_dec(modtune_r[`PTR_MT_DK1_LSB +: 2]);
      end else if (phases_nxt == 3'h2) begin
        tune_nxt.dead_band_reduced = modtune_r[`PTR_MT_DB2_BIT];
        tune_nxt.decay             = decay_dec(modtune_r[`PTR_MT_DK2_LSB +: 2]);
      end else begin
        tune_nxt.dead_band_reduced = modtune_r[`PTR_MT_DB3_BIT];
        tune_nxt.decay             = decay_dec(modtune_r[`PTR_MT_DK3_LSB +: 2]);
      end
    end
    tune_nxt.peak_cap_pf  = cap_pf(modtune_r[`PTR_MT_PKC_LSB +: 2]);
    tune_nxt.hpass_cap_pf = cap_pf(modtune_r[`PTR_MT_HPC_LSB +: 2]);
    tune_nxt.gain_double  = modtune_r[`PTR_MT_GAIN_BIT];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pstate_r         <= PTR_FULL;
      comp_offset_mv_r <= 8'h00;
      clamp_mv_r       <= `PTR_RST_CLAMP;
      phases_run_r     <= 3'h0;
      tune_active_r    <= 1'b0;
      tune_r           <= '0;
    end else begin
      pstate_r         <= pstate;
      comp_offset_mv_r <= offset_nxt;
      clamp_mv_r       <= clamp_nxt;
      phases_run_r     <= phases_nxt;
      tune_active_r    <= tune_act_nxt;
      tune_r           <= tune_nxt;
    end
  end
endmodule

// file: tb/ptr_host_model.sv
// management host model issuing register accesses on the command port
`timescale 1ns/10ps
module ptr_host_model (
  input  wire logic        clk,
  output logic [7:0]       cmd_code,
  output logic             cmd_wr,
  output logic [15:0]      cmd_wdata,
  output logic             cmd_rd,
  input  wire logic [15:0] cmd_rdata_r,
  input  wire logic        cmd_rvalid_r,
  input  wire logic        cmd_unmapped_r
);
  initial begin
    {cmd_code, cmd_wr, cmd_wdata, cmd_rd} = '0;
  end
  task automatic wr(input logic [7:0] c, input logic [15:0] w);
    @(posedge clk);
    cmd_code  <= c;
    cmd_wdata <= w;
    cmd_wr    <= 1'b1;
    @(posedge clk);
    cmd_wr    <= 1'b0;
    cmd_wdata <= ~w; // released bus never repeats the last word
  endtask
  task automatic rd(input logic [7:0] c, output logic [15:0] d, output logic u);
    @(posedge clk);
    cmd_code <= c;
    cmd_rd   <= 1'b1;
    @(posedge clk);
    cmd_rd <= 1'b0;
    @(negedge clk);
    d = cmd_rvalid_r ? cmd_rdata_r : 16'hxxxx;
    u = cmd_unmapped_r;
  endtask
endmodule

// file: tb/ptr_properties.sv
// port-level assertions for the tuning register bank
`timescale 1ns/10ps
module ptr_properties #(
  parameter int MAX_PHASES = 6
) (
  input wire logic                 clk,
  input wire logic                 rst_n,
  input wire logic [7:0]           cmd_code,
  input wire logic                 cmd_rd,
  input wire logic [15:0]          cmd_rdata_r,
  input wire logic                 cmd_rvalid_r,
  input wire logic                 cmd_unmapped_r,
  input wire logic [2:0]           nonvolatile_bank_select,
  input wire logic [2:0]           bank_addr_r,
  input wire logic                 low_voltage_trip_r,
  input wire logic                 low_voltage_warn_r,
  input wire logic                 hiccup_req_r,
  input wire logic [8:0]           prot_disable_r,
  input wire ptr_pkg::ptr_pstate_t pstate,
  input wire logic [2:0]           phases_run_r,
  input wire logic [2:0]           speedup_mode,
  input wire logic                 tune_active_r,
  input wire ptr_pkg::ptr_tune_t   tune_r
);
  import ptr_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_RD_ANSWER: assert property (cmd_rd |=> cmd_rvalid_r)
    else $error("read without answer");
  AST_UNMAPPED: assert property (cmd_rd && !(cmd_code inside {[8'he1:8'he3], 8'hdf})
    |=> cmd_unmapped_r && cmd_rdata_r == 16'h0000) else $error("unmapped read wrong");
  AST_RD_DATA: assert property (cmd_rd && cmd_code == 8'hdf
    |=> cmd_rdata_r == {7'h00, $past(prot_disable_r)}) else $error("mask read wrong");
  AST_UV_OFF: assert property (prot_disable_r[5] |=> !low_voltage_trip_r && !hiccup_req_r)
    else $error("trip while disabled");
  AST_WARN_OFF: assert property (prot_disable_r[8] |=> !low_voltage_warn_r)
    else $error("warning while disabled");
  AST_HICCUP: assert property (hiccup_req_r |-> low_voltage_trip_r)
    else $error("restart without trip");
  AST_BANK_ADDR: assert property (rst_n
    |=> bank_addr_r == $past(nonvolatile_bank_select)) else $error("bank address lags");
  AST_FULL_PH: assert property (rst_n && pstate == PTR_FULL
    |=> phases_run_r == 3'(MAX_PHASES)) else $error("full state phase count wrong");
  AST_TUNE_OFF: assert property (rst_n && speedup_mode != 3'h0 |=> !tune_active_r &&
    !tune_r.dead_band_reduced && tune_r.decay == PTR_DK_NORMAL) else $error("tuning not idle");
  cover property ($rose(low_voltage_trip_r));
  cover property (hiccup_req_r);
  cover property (cmd_unmapped_r);
endmodule
bind ptr_top ptr_properties #(.MAX_PHASES(MAX_PHASES)) u_props (.clk, .rst_n, .cmd_code,
  .cmd_rd, .cmd_rdata_r, .cmd_rvalid_r, .cmd_unmapped_r, .nonvolatile_bank_select,
  .bank_addr_r, .low_voltage_trip_r, .low_voltage_warn_r, .hiccup_req_r, .prot_disable_r,
  .pstate, .phases_run_r, .speedup_mode, .tune_active_r, .tune_r);

// file: tb/tb.sv
// self-checking bench for the protection and loop tuning register bank
`timescale 1ns/10ps
module tb;
  import ptr_pkg::*;
  typedef struct {logic [7:0] c; logic [15:0] w; logic [15:0] r; logic u;} ptr_row_t;
  // upper bits set on purpose: they must be dropped
  ptr_row_t rows [6] = '{'{8'hdf, 16'hffff, 16'h01ff, 1'b0}, '{8'he1, 16'hff45, 16'h0045, 1'b0},
    '{8'he2, 16'hfabc, 16'h0abc, 1'b0}, '{8'he3, 16'hf123, 16'h3123, 1'b0},
    '{8'he0, 16'h1234, 16'h0000, 1'b1}, '{8'hdf, 16'h0000, 16'h0000, 1'b0}};
  logic [7:0]   codes [4] = '{8'hdf, 8'he1, 8'he2, 8'he3};
  ptr_pstate_t  pst [4] = '{PTR_REDUCED, PTR_FULL, PTR_DIODE, PTR_FULL};
  logic [15:0]  offs [4] = '{16'h0000, 16'h003c, 16'h0064, 16'h0000};
  ptr_decay_t   dk [4] = '{PTR_DK_HALF, PTR_DK_NORMAL, PTR_DK_QUARTER, PTR_DK_HALF};
  int           mv [8] = '{105, 141, 178, 214, 252, 291, 328, 402};
  int           uv [6][3] = '{'{0, 0, 1}, '{-1, 1, 1}, '{18, 1, 1}, '{19, 0, 1}, '{82, 0, 1},
    '{83, 0, 0}};
  int           dly [4] = '{4, 6, 8, 10};
  logic         clk = 1'b0, rst_n = 1'b0, bank_load = 1'b0, u;
  logic         cmd_wr, cmd_rd, cmd_rvalid_r, cmd_unmapped_r, tune_active_r;
  logic         low_voltage_trip_r, low_voltage_warn_r, hiccup_req_r;
  logic [7:0]   cmd_code, comp_offset_mv_r;
  logic [15:0]  cmd_wdata, cmd_rdata_r, d;
  logic [2:0]   nonvolatile_bank_select = 3'h0, speedup_mode = 3'h0, bank_addr_r, phases_run_r;
  logic [11:0]  vout_mv = 12'h3e8, dac_mv = 12'h3e8;
  logic [8:0]   prot_disable_r;
  logic [6:0]   clamp_mv_r;
  logic [1:0]   reduced_phase_count = 2'h1;
  ptr_bank_t    bank_data = '0;
  ptr_pstate_t  pstate = PTR_FULL;
  ptr_tune_t    tune_r, te;
  int           failures = 0, comparisons = 0, cycles = 0;
  // short persistence counts keep the run brief
  ptr_top #(.DLY0_CYC(4), .DLY1_CYC(6), .DLY2_CYC(8), .DLY3_CYC(10)) dut (.clk, .rst_n,
    .cmd_code, .cmd_wr, .cmd_wdata, .cmd_rd, .cmd_rdata_r, .cmd_rvalid_r, .cmd_unmapped_r,
    .nonvolatile_bank_select, .bank_load, .bank_data, .bank_addr_r, .vout_mv, .dac_mv,
    .low_voltage_trip_r, .low_voltage_warn_r, .hiccup_req_r, .prot_disable_r, .pstate,
    .reduced_phase_count, .speedup_mode, .phases_run_r, .comp_offset_mv_r, .clamp_mv_r,
    .tune_active_r, .tune_r);
  ptr_host_model host (.clk, .cmd_code, .cmd_wr, .cmd_wdata, .cmd_rd, .cmd_rdata_r,
    .cmd_rvalid_r, .cmd_unmapped_r);
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      conclude();
    end
  end
  task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  initial begin
    int thr, n;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    foreach (codes[i]) begin
      host.rd(codes[i], d, u);
      cmp("reset value", 16'h0000, d);
    end
    foreach (rows[i]) begin
      host.wr(rows[i].c, rows[i].w);
      host.rd(rows[i].c, d, u);
      cmp("read data", rows[i].r, d);
      cmp("unmapped flag", {15'h0, rows[i].u}, {15'h0, u});
    end
    @(posedge clk);
    nonvolatile_bank_select <= 3'h5;
    bank_data <= '{9'h1a5, 7'h2b, 12'h9c3, 14'h2d4e};
    bank_load <= 1'b1;
    @(posedge clk);
    bank_load <= 1'b0;
    host.rd(8'he2, d, u);
    cmp("loaded value", 16'h09c3, d);
    cmp("bank_addr_r", 16'h0005, {13'h0, bank_addr_r});
    for (int k = 0; k < 4; k++) begin
      host.wr(8'he2, 16'h0767 | 16'(k << 3));
      wt(1);
      cmp("clamp_mv_r", 16'((k + 1) * 20), {9'h0, clamp_mv_r});
    end
    foreach (pst[i]) begin
      @(posedge clk);
      pstate <= pst[i];
      wt(2);
      cmp("comp_offset_mv_r", offs[i], {8'h0, comp_offset_mv_r});
    end
    @(posedge clk);
    pstate <= PTR_REDUCED;
    for (int k = 0; k < 4; k++) begin
      host.wr(8'he3, 16'h2748 | 16'(k << 1));
      wt(2);
      te = '{1'b0, dk[k], 3'h4, 3'h1, 1'b1};
      cmp("tune_r", {6'h0, te}, {6'h0, tune_r});
    end
    cmp("phases_run_r", 16'h0001, {13'h0, phases_run_r});
    cmp("tune_active_r", 16'h0001, {15'h0, tune_active_r});
    @(posedge clk);
    reduced_phase_count <= 2'h2;
    wt(2);
    cmp("phases_run_r", 16'h0002, {13'h0, phases_run_r});
    te = '{1'b1, PTR_DK_HALF, 3'h4, 3'h1, 1'b1};
    cmp("tune_r", {6'h0, te}, {6'h0, tune_r});
    @(posedge clk);
    pstate <= PTR_FULL;
    wt(2);
    cmp("phases_run_r", 16'h0006, {13'h0, phases_run_r});
    te = '{1'b1, PTR_DK_QUARTER, 3'h4, 3'h1, 1'b1};
    cmp("tune_r", {6'h0, te}, {6'h0, tune_r});
    @(posedge clk);
    speedup_mode <= 3'h1;
    wt(2);
    te = '{1'b0, PTR_DK_NORMAL, 3'h4, 3'h1, 1'b1};
    cmp("tune_r", {6'h0, te}, {6'h0, tune_r});
    cmp("tune_active_r", 16'h0000, {15'h0, tune_active_r});
    host.wr(8'hdf, 16'h0000);
    for (int k = 0; k < 8; k++) begin
      host.wr(8'he1, 16'(k | ((k & 1) << 6)));
      thr = 1000 - mv[k];
      foreach (uv[j]) begin
        @(posedge clk);
        vout_mv <= 12'(thr + uv[j][0]);
        wt(10);
        cmp("low_voltage_trip_r", 16'(uv[j][1]), {15'h0, low_voltage_trip_r});
        cmp("low_voltage_warn_r", 16'(uv[j][2]), {15'h0, low_voltage_warn_r});
        cmp("hiccup_req_r", 16'(uv[j][1] & k & 1), {15'h0, hiccup_req_r});
      end
    end
    // back to nominal first, or the shallower level trips before timing starts
    @(posedge clk);
    vout_mv <= 12'h3e8;
    wt(4);
    for (int k = 0; k < 4; k++) begin
      host.wr(8'he1, 16'h0040 | 16'(k << 4));
      @(posedge clk);
      vout_mv <= 12'h352;
      n = 0;
      do begin
        @(posedge clk);
        #1;
        n++;
      end while (low_voltage_trip_r !== 1'b1 && n < 40);
      cmp("trip delay", 16'(dly[k] + 2), 16'(n));
      cmp("hiccup_req_r", 16'h0001, {15'h0, hiccup_req_r});
      @(posedge clk);
      vout_mv <= 12'h3e8;
      wt(4);
    end
    @(posedge clk);
    vout_mv <= 12'h352;
    wt(16);
    cmp("trip armed", 16'h0001, {15'h0, low_voltage_trip_r});
    host.wr(8'hdf, 16'h0120);
    wt(2);
    cmp("prot_disable_r", 16'h0120, {7'h0, prot_disable_r});
    cmp("trip warn hiccup", 16'h0000, {13'h0, low_voltage_trip_r, low_voltage_warn_r,
      hiccup_req_r});
    // second reset in mid-run, with a bank selected and disables set
    @(posedge clk);
    rst_n <= 1'b0;
    wt(2);
    cmp("clamp_mv_r in reset", 16'h0014, {9'h0, clamp_mv_r});
    cmp("prot_disable_r in reset", 16'h0000, {7'h0, prot_disable_r});
    @(posedge clk);
    rst_n <= 1'b1;
    host.rd(8'he3, d, u);
    cmp("value after reset", 16'h0000, d);
    conclude();
  end
endmodule
